// [hdl/pfs_pkg.sv]
// constants and types for the program flash self-access controller
package pfs_pkg;
  // register selects on the core register port
  localparam logic [2:0] SEL_ADDR_LOW = 3'h0;
  localparam logic [2:0] SEL_ADDR_HIGH = 3'h1;
  localparam logic [2:0] SEL_DATA_LOW = 3'h2;
  localparam logic [2:0] SEL_DATA_HIGH = 3'h3;
  localparam logic [2:0] SEL_CONTROL = 3'h4;
  localparam logic [2:0] SEL_UNLOCK_KEY = 3'h5;
  // control register bit positions
  localparam int BIT_SPACE = 7;
  localparam int BIT_WALLOW = 2;
  localparam int BIT_WR = 1;
  localparam int BIT_RD = 0;
  // unlock keys
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  // widths
  localparam int ADDR_W = 11;
  localparam int WORD_W = 14;
  localparam int ADDR_HI_W = ADDR_W - 8;
  localparam int DATA_HI_W = WORD_W - 8;
  // code protect encodings and protected segment starts
  localparam logic [1:0] CP_FULL = 2'h0;
  localparam logic [1:0] CP_UPPER_HALF = 2'h1;
  localparam logic [1:0] CP_TOP_PART = 2'h2;
  localparam logic [1:0] CP_NONE = 2'h3;
  localparam logic [ADDR_W-1:0] SEG_HALF = 11'h400;
  localparam logic [ADDR_W-1:0] SEG_TOP = 11'h700;
  // unlock sequence progress
  localparam logic [1:0] KEY_IDLE = 2'h0;
  localparam logic [1:0] KEY_GOT55 = 2'h1;
  localparam logic [1:0] KEY_GOTAA = 2'h2;
  // power-up timer
  localparam int CLK_HZ = 25000000;
  localparam int PWRT_TIME_MS = 72;
  localparam int PWRT_CYC_DEF = PWRT_TIME_MS * (CLK_HZ / 1000);
  localparam int PWRT_W = 21;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_RD1 = 6'b000010,
    ST_RD2 = 6'b000100,
    ST_WR1 = 6'b001000,
    ST_WR2 = 6'b010000,
    ST_EEW = 6'b100000
  } pfs_state_e;

  typedef struct packed {
    pfs_state_e st;
    logic [1:0] key;
    logic [7:0] addr_lo;
    logic [7:0] addr_hi;
    logic [7:0] dat_lo;
    logic [7:0] dat_hi;
    logic space;
    logic wallow;
    logic wr;
    logic rd;
    logic done;
    logic stall;
    logic fl_rd;
    logic fl_wr;
    logic ee_req;
    logic [PWRT_W-1:0] pwrt_cnt;
    logic pwrt_run;
    logic ext_lock;
    logic ext_rw_en;
    logic ext_prog_en;
  } pfs_regs_s;
endpackage

// [hdl/pfs_ctrl.sv]
// program flash self-access controller with write protection gating
`timescale 1ns/10ps
// Functional notes
// - read trigger fetches the word over two cycles into the data registers
// - data registers hold the fetched word until a new read or a software write
// - full or no code protection: flash writes allowed only with self-write permit
// - partial protection: write needs unprotected target and self-write permit
// - write starts only after keys 55h then AAh then trigger, write-allow set
// - flash write stalls the core for two cycles; clocks keep running
// - the two instructions after the trigger are ignored; software places no-ops
// - execution resumes at the third instruction after the trigger
// - write-allow is cleared at power-up
// - data EEPROM writes blocked while the power-up timer runs
// - self-write permit at zero refuses every self flash write
// - user code cannot change the self-write permit or configuration word
// - any code protection disables external read and write
// - internal data EEPROM access ignores the data code-protect bit
// - data code-protect at zero disables external program memory access
// - external program access returns only after bulk erase with protection removed; read/write returns at once
// - write end clears write trigger and sets the done flag, cleared by software
// - write trigger refused unless write-allow was set by an earlier write
module pfs_ctrl #(
  parameter int PWRT_CYC = pfs_pkg::PWRT_CYC_DEF
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic CE,
  input wire logic REG_WE,
  input wire logic [2:0] REG_SEL,
  input wire logic [7:0] REG_WDATA,
  input wire logic DONE_CLR,
  input wire logic CFG_SELF_WRITE_PERMIT,
  input wire logic [1:0] CFG_CODE_PROT,
  input wire logic CFG_DATA_PROT_N,
  input wire logic BULK_ERASE_DONE,
  input wire logic [pfs_pkg::WORD_W-1:0] FL_RDATA,
  input wire logic EE_WR_DONE,
  output logic [7:0] ADDR_LOW,
  output logic [7:0] ADDR_HIGH,
  output logic [7:0] DATA_LOW,
  output logic [7:0] DATA_HIGH,
  output logic [7:0] CONTROL,
  output logic WRITE_DONE_FLAG,
  output logic CPU_STALL,
  output logic [pfs_pkg::ADDR_W-1:0] FL_ADDR,
  output logic [pfs_pkg::WORD_W-1:0] FL_WDATA,
  output logic FL_RD,
  output logic FL_WR,
  output logic EE_WR_REQ,
  output logic PWRT_RUNNING,
  output logic EXT_RW_EN,
  output logic EXT_PROG_EN
);
  import pfs_pkg::*;

  pfs_regs_s r;
  pfs_regs_s n;
  logic [ADDR_W-1:0] waddr;
  logic ctl_we;
  logic key_we;
  logic trig_wr;
  logic trig_rd;
  logic flash_start;
  logic ee_start;

  // ---------------------------------------------
  // write permission for a flash word
  // ---------------------------------------------
  function automatic logic flash_permit(input logic [ADDR_W-1:0] a, input logic [1:0] cp,
                                        input logic permit);
    logic ok;
    ok = 1'b0;
    if (permit) begin
      case (cp)
        CP_FULL, CP_NONE: ok = 1'b1;
        CP_UPPER_HALF: ok = (a < SEG_HALF);
        CP_TOP_PART: ok = (a < SEG_TOP);
        default: ok = 1'b0;
      endcase
    end
    return ok;
  endfunction

  assign waddr = {r.addr_hi[ADDR_HI_W-1:0], r.addr_lo};

  // ---------------------------------------------
  // register writes and triggers
  // ---------------------------------------------
  always_comb begin
    // the core is halted while stalled, so its writes are ignored
    ctl_we = REG_WE && !r.stall && (REG_SEL == SEL_CONTROL);
    key_we = REG_WE && !r.stall && (REG_SEL == SEL_UNLOCK_KEY);
    // trigger only counts the write-allow held before this write
    trig_wr = ctl_we && REG_WDATA[BIT_WR] && r.wallow && !r.wr && (r.key == KEY_GOTAA)
              && (r.st == ST_IDLE);
    trig_rd = ctl_we && REG_WDATA[BIT_RD] && REG_WDATA[BIT_SPACE] && (r.st == ST_IDLE);
    flash_start = trig_wr && REG_WDATA[BIT_SPACE]
                  && flash_permit(waddr, CFG_CODE_PROT, CFG_SELF_WRITE_PERMIT);
    // data writes ignore the data code-protect bit, only the power-up timer blocks
    ee_start = trig_wr && !REG_WDATA[BIT_SPACE] && !r.pwrt_run;
  end

  // ---------------------------------------------
  // next state
  // ---------------------------------------------
  always_comb begin
    n = r;
    n.fl_rd = 1'b0;
    n.fl_wr = 1'b0;
    n.ee_req = 1'b0;
    if (REG_WE && !r.stall) begin
      case (REG_SEL)
        SEL_ADDR_LOW: n.addr_lo = REG_WDATA;
        SEL_ADDR_HIGH: n.addr_hi = {{(8-ADDR_HI_W){1'b0}}, REG_WDATA[ADDR_HI_W-1:0]};
        SEL_DATA_LOW: n.dat_lo = REG_WDATA;
        SEL_DATA_HIGH: n.dat_hi = {{(8-DATA_HI_W){1'b0}}, REG_WDATA[DATA_HI_W-1:0]};
        SEL_CONTROL: begin
          n.space = REG_WDATA[BIT_SPACE];
          n.wallow = REG_WDATA[BIT_WALLOW];
        end
        default: ;
      endcase
    end
    // unlock keys must arrive back to back, any other write breaks the sequence
    if (REG_WE && !r.stall) begin
      if (key_we && REG_WDATA == KEY_FIRST) begin
        n.key = KEY_GOT55;
      end else if (key_we && REG_WDATA == KEY_SECOND && r.key == KEY_GOT55) begin
        n.key = KEY_GOTAA;
      end else begin
        n.key = KEY_IDLE;
      end
    end
    case (r.st)
      ST_IDLE: begin
        if (trig_rd) begin
          n.rd = 1'b1;
          n.fl_rd = 1'b1;
          n.st = ST_RD1;
        end else if (flash_start) begin
          n.wr = 1'b1;
          n.stall = 1'b1;
          n.fl_wr = 1'b1;
          n.st = ST_WR1;
        end else if (ee_start) begin
          n.wr = 1'b1;
          n.ee_req = 1'b1;
          n.st = ST_EEW;
        end
      end
      ST_RD1: begin
        n.fl_rd = 1'b1;
        n.st = ST_RD2;
      end
      ST_RD2: begin
        n.dat_lo = FL_RDATA[7:0];
        n.dat_hi = {{(8-DATA_HI_W){1'b0}}, FL_RDATA[WORD_W-1:8]};
        n.rd = 1'b0;
        n.st = ST_IDLE;
      end
      ST_WR1: begin
        n.fl_wr = 1'b1;
        n.st = ST_WR2;
      end
      ST_WR2: begin
        n.stall = 1'b0;
        n.wr = 1'b0;
        n.done = 1'b1;
        n.st = ST_IDLE;
      end
      ST_EEW: begin
        if (EE_WR_DONE) begin
          n.wr = 1'b0;
          n.done = 1'b1;
          n.st = ST_IDLE;
        end
      end
      default: n.st = ST_IDLE;
    endcase
    // software clear loses against a completion in the same cycle
    if (DONE_CLR && !((r.st == ST_WR2) || (r.st == ST_EEW && EE_WR_DONE))) begin
      n.done = 1'b0;
    end
    if (r.pwrt_run) begin
      if (r.pwrt_cnt == PWRT_W'(PWRT_CYC - 1)) begin
        n.pwrt_run = 1'b0;
      end else begin
        n.pwrt_cnt = r.pwrt_cnt + 1'b1;
      end
    end
    // configuration bits are inputs only; no path from the core changes them
    if (!CFG_DATA_PROT_N) begin
      n.ext_lock = 1'b1;
    end else if (BULK_ERASE_DONE && CFG_CODE_PROT == CP_NONE) begin
      n.ext_lock = 1'b0;
    end
    n.ext_rw_en = (CFG_CODE_PROT == CP_NONE) && CFG_DATA_PROT_N;
    n.ext_prog_en = (CFG_CODE_PROT == CP_NONE) && CFG_DATA_PROT_N && !n.ext_lock;
  end

  // ---------------------------------------------
  // state register
  // ---------------------------------------------
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      r <= '0;
      r.st <= ST_IDLE;
      r.wallow <= 1'b0;
      r.pwrt_run <= 1'b1;
    end else if (CE) begin
      r <= n;
    end
  end

  // ---------------------------------------------
  // outputs
  // ---------------------------------------------
  assign ADDR_LOW = r.addr_lo;
  assign ADDR_HIGH = r.addr_hi;
  assign DATA_LOW = r.dat_lo;
  assign DATA_HIGH = r.dat_hi;
  assign CONTROL = {r.space, 4'h0, r.wallow, r.wr, r.rd};
  assign WRITE_DONE_FLAG = r.done;
  assign CPU_STALL = r.stall;
  assign FL_ADDR = waddr;
  assign FL_WDATA = {r.dat_hi[DATA_HI_W-1:0], r.dat_lo};
  assign FL_RD = r.fl_rd;
  assign FL_WR = r.fl_wr;
  assign EE_WR_REQ = r.ee_req;
  assign PWRT_RUNNING = r.pwrt_run;
  assign EXT_RW_EN = r.ext_rw_en;
  assign EXT_PROG_EN = r.ext_prog_en;

  // ---------------------------------------------
  // assertions
  // ---------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  stall_two_a: assert property ((r.st == ST_IDLE) && !r.stall ##1 r.stall |-> r.st == ST_WR1)
    else $error("stall raised without a flash write start");
  stall_end_a: assert property (r.stall && CE && (r.st == ST_WR2) |=> !r.stall && r.done)
    else $error("stall did not end with the done flag");
  wr_needs_key_a: assert property (CE && flash_start |-> r.key == KEY_GOTAA && r.wallow)
    else $error("flash write started without unlock and write-allow");
  permit_off_a: assert property (!CFG_SELF_WRITE_PERMIT && CE |=> r.st != ST_WR1)
    else $error("flash write started with self-write permit clear");
  rd_capture_a: assert property (CE && (r.st == ST_RD2) |=> DATA_LOW == $past(FL_RDATA[7:0]))
    else $error("read data not captured after two cycles");
  data_hold_a: assert property (CE && (r.st == ST_IDLE) && !REG_WE |=> $stable(DATA_LOW))
    else $error("data register changed without read or write");
  ee_pwrt_a: assert property (r.pwrt_run |-> !EE_WR_REQ)
    else $error("data write requested while power-up timer runs");
  ext_prot_a: assert property (CE && (CFG_CODE_PROT != CP_NONE) |=> !EXT_RW_EN)
    else $error("external access enabled under code protection");
  done_set_a: assert property (CE && DONE_CLR && (r.st == ST_WR2) |=> r.done)
    else $error("done flag lost to a simultaneous clear");
endmodule // pfs_ctrl

// [verif/pfs_ctrl_bench.sv]
// self-checking bench for the program flash self-access controller
`timescale 1ns/10ps
module pfs_ctrl_bench;
  import pfs_pkg::*;
  localparam int PCYC = 200;
  logic CLK = 1'b0;
  logic ARST_N = 1'b0;
  logic CE = 1'b1;
  logic REG_WE = 1'b0;
  logic [2:0] REG_SEL = 3'h0;
  logic [7:0] REG_WDATA = 8'h00;
  logic DONE_CLR = 1'b0;
  logic PERMIT = 1'b1;
  logic [1:0] CPROT = CP_NONE;
  logic DPROT_N = 1'b1;
  logic ERASED = 1'b0;
  logic [WORD_W-1:0] FL_RDATA = 14'h1A5C;
  logic EE_DONE = 1'b0;
  logic [7:0] ADDR_LOW, ADDR_HIGH, DATA_LOW, DATA_HIGH, CONTROL;
  logic WRITE_DONE_FLAG, CPU_STALL, FL_RD, FL_WR, EE_WR_REQ, PWRT_RUNNING, EXT_RW_EN, EXT_PROG_EN;
  logic [ADDR_W-1:0] FL_ADDR;
  logic [WORD_W-1:0] FL_WDATA;
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0;
  pfs_ctrl #(.PWRT_CYC(PCYC)) dut_u (.CLK(CLK), .ARST_N(ARST_N), .CE(CE), .REG_WE(REG_WE),
    .REG_SEL(REG_SEL), .REG_WDATA(REG_WDATA), .DONE_CLR(DONE_CLR),
    .CFG_SELF_WRITE_PERMIT(PERMIT), .CFG_CODE_PROT(CPROT), .CFG_DATA_PROT_N(DPROT_N),
    .BULK_ERASE_DONE(ERASED), .FL_RDATA(FL_RDATA), .EE_WR_DONE(EE_DONE), .ADDR_LOW(ADDR_LOW),
    .ADDR_HIGH(ADDR_HIGH), .DATA_LOW(DATA_LOW), .DATA_HIGH(DATA_HIGH), .CONTROL(CONTROL),
    .WRITE_DONE_FLAG(WRITE_DONE_FLAG), .CPU_STALL(CPU_STALL), .FL_ADDR(FL_ADDR),
    .FL_WDATA(FL_WDATA), .FL_RD(FL_RD), .FL_WR(FL_WR), .EE_WR_REQ(EE_WR_REQ),
    .PWRT_RUNNING(PWRT_RUNNING), .EXT_RW_EN(EXT_RW_EN), .EXT_PROG_EN(EXT_PROG_EN));
  initial begin
    forever #20 CLK = ~CLK;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count = bad_count + 1;
      final_report();
    end
  end
  task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // a cycle with the strobe low, then one write strobe
  task wr(input logic [2:0] s, input logic [7:0] d);
    @(negedge CLK);
    REG_SEL = s;
    REG_WDATA = d;
    REG_WE = 1'b1;
    @(negedge CLK);
    REG_WE = 1'b0;
  endtask
  // keys go back to back with nothing in between, as with interrupts masked
  task unlock;
    wr(SEL_UNLOCK_KEY, KEY_FIRST);
    wr(SEL_UNLOCK_KEY, KEY_SECOND);
  endtask
  // drive the flash read data with a word, read it back and compare it with that word
  task rdback(input logic [10:0] a, input logic [13:0] d);
    FL_RDATA = d;
    wr(SEL_ADDR_LOW, a[7:0]);
    wr(SEL_ADDR_HIGH, {5'h00, a[10:8]});
    wr(SEL_CONTROL, 8'h81);
    @(negedge CLK);
    @(negedge CLK);
    chk({DATA_HIGH[5:0], DATA_LOW}, d, "read back");
  endtask
  task clr_flag;
    DONE_CLR = 1'b1;
    @(negedge CLK);
    DONE_CLR = 1'b0;
    @(negedge CLK);
    chk(WRITE_DONE_FLAG, 0, "flag clear");
  endtask
  task fwrite(input logic [10:0] a, input logic [13:0] d, input logic ok);
    wr(SEL_ADDR_LOW, a[7:0]);
    wr(SEL_ADDR_HIGH, {5'h00, a[10:8]});
    wr(SEL_DATA_LOW, d[7:0]);
    wr(SEL_DATA_HIGH, {2'h0, d[13:8]});
    wr(SEL_CONTROL, 8'h84);
    unlock();
    wr(SEL_CONTROL, 8'h86);
    chk(CPU_STALL, ok, "stall c1");
    chk(FL_WR, ok, "flash write c1");
    chk({FL_ADDR, 5'h00}, {a, 5'h00}, "write addr");
    chk(FL_WDATA, d, "write word");
    @(negedge CLK);
    chk(CPU_STALL, ok, "stall c2");
    @(negedge CLK);
    chk(CPU_STALL, 0, "resume");
    chk(WRITE_DONE_FLAG, ok, "done flag");
    chk(CONTROL, 8'h84, "trigger cleared");
    clr_flag();
  endtask
  task ext_chk(input logic rw, input logic pg);
    @(negedge CLK);
    @(negedge CLK);
    chk(EXT_RW_EN, rw, "ext rw");
    chk(EXT_PROG_EN, pg, "ext prog");
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task s_data_write;
    wr(SEL_CONTROL, 8'h04);
    unlock();
    wr(SEL_CONTROL, 8'h06);
    chk(EE_WR_REQ, DPROT_N ? 0 : 1, "data write request");
    @(negedge CLK);
    chk(EE_WR_REQ, 0, "request one cycle");
    EE_DONE = 1'b1;
    @(negedge CLK);
    EE_DONE = 1'b0;
    chk(CONTROL, 8'h04, "data trigger cleared");
  endtask
  task s_read;
    wr(SEL_ADDR_LOW, 8'hA3);
    wr(SEL_ADDR_HIGH, 8'h05);
    wr(SEL_CONTROL, 8'h81);
    chk(FL_RD, 1, "read c1");
    chk(FL_ADDR, 11'h5A3, "read addr");
    @(negedge CLK);
    chk(FL_RD, 1, "read c2");
    @(negedge CLK);
    chk({DATA_HIGH, DATA_LOW}, 16'h1A5C, "read word");
    chk(CONTROL, 8'h80, "read trigger cleared");
    FL_RDATA = 14'h0F0F;
    @(negedge CLK);
    @(negedge CLK);
    chk({DATA_HIGH, DATA_LOW}, 16'h1A5C, "data held");
  endtask
  task s_refusals;
    wr(SEL_CONTROL, 8'h84);
    wr(SEL_CONTROL, 8'h86);
    chk(CPU_STALL, 0, "no keys");
    wr(SEL_CONTROL, 8'h80);
    unlock();
    wr(SEL_CONTROL, 8'h86);
    chk(CPU_STALL, 0, "allow with trigger");
    chk(CONTROL[1], 0, "trigger refused");
  endtask
  initial begin
    repeat (10) @(negedge CLK);
    ARST_N = 1'b1;
    chk(CONTROL, 8'h00, "control at reset");
    chk(PWRT_RUNNING, 1, "timer running");
    s_data_write();
    clr_flag();
    repeat (PCYC) @(negedge CLK);
    chk(PWRT_RUNNING, 0, "timer over");
    DPROT_N = 1'b0;
    s_data_write();
    chk(WRITE_DONE_FLAG, 1, "data done flag");
    clr_flag();
    ext_chk(0, 0);
    DPROT_N = 1'b1;
    ext_chk(1, 0);
    ERASED = 1'b1;
    @(negedge CLK);
    ERASED = 1'b0;
    ext_chk(1, 1);
    CPROT = CP_FULL;
    ext_chk(0, 0);
    s_read();
    fwrite(11'h123, 14'h2ABC, 1);
    s_refusals();
    PERMIT = 1'b0;
    fwrite(11'h010, 14'h0001, 0);
    CPROT = CP_NONE;
    fwrite(11'h011, 14'h0002, 0);
    PERMIT = 1'b1;
    CPROT = CP_UPPER_HALF;
    fwrite(11'h400, 14'h3FFF, 0);
    fwrite(11'h3FF, 14'h1234, 1);
    rdback(11'h3FF, 14'h1234);
    CPROT = CP_TOP_PART;
    fwrite(11'h700, 14'h0555, 0);
    fwrite(11'h6FF, 14'h2AAA, 1);
    final_report();
  end
endmodule // pfs_ctrl_bench
